// ===== shared/tw_pkg.sv
// Purpose: shared constants and types of the two-wire bus controller and its bus peer
// Assumes: 32-bit APB, one aligned word per register, 125 MHz pclk
// Notes: register payload sits in the low byte, upper bits read zero
package tw_pkg;
	localparam int AW = 8;
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_DATA  = 8'h08;
	localparam logic [7:0] OFF_CTRL2 = 8'h0c;
	localparam logic [7:0] OFF_SADDR = 8'h10;
	// Primary control fields
	localparam int B_EN     = 7;
	localparam int B_IE     = 6;
	localparam int B_MST    = 5;
	localparam int B_TX     = 4;
	localparam int B_ACKDIS = 3;
	localparam int B_REPEAT_START_CMD   = 2;
	// Status fields
	localparam int B_TCF  = 7;
	localparam int B_SLAVE_ADDRESSED_FLAG = 6;
	localparam int B_BUSY = 5;
	localparam int B_ARBITRATION_LOST_FLAG = 4;
	localparam int B_SRW  = 2;
	localparam int B_IIF  = 1;
	localparam int B_RECEIVED_ACK_FLAG = 0;
	// Secondary control field
	localparam int B_GCEN = 7;
	localparam logic [6:0] GC_ADDR   = 7'h00;
	localparam logic [6:0] RST_SADDR = 7'h00;
	localparam logic [6:0] PEER_ADDR = 7'h2a;
	localparam logic       RST_TCF   = 1'b1;
	localparam logic       RST_RECEIVED_ACK_FLAG  = 1'b1;
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] ACK_SLOT  = 4'h8;
	// Bus timing: half of one serial clock period
	localparam int CLK_NS       = 8;
	localparam int SCL_HALF_NS  = 5000;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int TW           = 16;
	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_MSTART = 9'h002,
		ST_MLOW   = 9'h004,
		ST_MHIGH  = 9'h008,
		ST_HOLD   = 9'h010,
		ST_MSTOP  = 9'h020,
		ST_MRSTA  = 9'h040,
		ST_SBIT   = 9'h080,
		ST_SWAIT  = 9'h100
	} tw_state_t;
	typedef enum logic [2:0] {
		PS_IDLE = 3'h1,
		PS_BITS = 3'h2,
		PS_SKIP = 3'h4
	} tw_peer_state_t;
endpackage

// ===== shared/tw_bus_if.sv
// Purpose: open-drain clock and data wires shared by the controller and a bus peer
// Assumes: pull-ups modelled as a wired AND of released drivers
// Notes: an enable low means that party pulls the line to its output value
`timescale 1ns/1ps
interface tw_bus_if;
	logic dev_scl_o;
	logic dev_scl_oen;
	logic dev_sda_o;
	logic dev_sda_oen;
	logic peer_scl_o;
	logic peer_scl_oen;
	logic peer_sda_o;
	logic peer_sda_oen;
	logic scl;
	logic sda;
	assign scl = (dev_scl_oen | dev_scl_o) & (peer_scl_oen | peer_scl_o);
	assign sda = (dev_sda_oen | dev_sda_o) & (peer_sda_oen | peer_sda_o);
	modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oen, output dev_sda_o, output dev_sda_oen);
	modport peer (input scl, input sda, output peer_scl_o, output peer_scl_oen, output peer_sda_o, output peer_sda_oen);
endinterface

// ===== rtl/tw_peer.sv
// Purpose: bus peer, a plain addressed target on the two-wire bus
// Assumes: the controller is the only master; peer never stretches unless told
// Notes: hold inputs let a bench force contention or clock stretching
`timescale 1ns/1ps
module tw_peer #(
	parameter logic [6:0] ADDR = tw_pkg::PEER_ADDR
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] tx_byte,
	input  wire logic       hold_scl,
	input  wire logic       hold_sda,
	output logic      [7:0] rx_byte,
	output logic            rx_strobe,
	output logic            addressed,
	tw_bus_if.peer          tw
);
	tw_pkg::tw_peer_state_t state;
	logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic       bit_in, ack_me, is_addr, rd;

	wire logic       start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire logic       stop_det  = scl_s & scl_d & ~sda_d & sda_s;
	wire logic       scl_rise  = scl_s & ~scl_d;
	wire logic       scl_fall  = ~scl_s & scl_d;
	wire logic [7:0] byte_in   = {sh[6:0], bit_in};
	wire logic       in_bits   = state == tw_pkg::PS_BITS;
	wire logic       data_pull = (cnt != tw_pkg::ACK_SLOT) ? (rd & ~is_addr & ~sh[7]) : ack_me;

	assign tw.peer_scl_o   = 1'b0;
	assign tw.peer_sda_o   = 1'b0;
	assign tw.peer_scl_oen = ~hold_scl;
	assign tw.peer_sda_oen = ~(hold_sda | (in_bits & data_pull));

	// Two stages before any logic reads the wires
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {tw.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {tw.sda, sda_m, sda_s};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= tw_pkg::PS_IDLE;
			cnt       <= 4'h0;
			sh        <= 8'hff;
			bit_in    <= 1'b1;
			ack_me    <= 1'b0;
			is_addr   <= 1'b0;
			rd        <= 1'b0;
			rx_byte   <= 8'h00;
			rx_strobe <= 1'b0;
			addressed <= 1'b0;
		end else begin
			rx_strobe <= 1'b0;
			if (in_bits && scl_rise)
				bit_in <= sda_s;
			if (in_bits && scl_fall) begin
				if (cnt != tw_pkg::ACK_SLOT) begin
					sh  <= byte_in;
					cnt <= 4'(cnt + 4'h1);
					if (cnt == tw_pkg::LAST_BIT) begin
						ack_me <= is_addr ? (byte_in[7:1] == ADDR) : ~rd;
						if (!is_addr && !rd) begin
							rx_byte   <= byte_in;
							rx_strobe <= 1'b1;
						end
					end
				end else begin
					cnt    <= 4'h0;
					ack_me <= 1'b0;
					if (is_addr) begin
						is_addr   <= 1'b0;
						rd        <= sh[0];
						addressed <= ack_me;
						if (!ack_me)
							state <= tw_pkg::PS_SKIP;
						else if (sh[0])
							sh <= tx_byte;
					end else if (rd && bit_in) begin
						// Master declined more data
						state <= tw_pkg::PS_SKIP;
					end else if (rd) begin
						sh <= tx_byte;
					end
				end
			end
			if (start_det) begin
				state   <= tw_pkg::PS_BITS;
				cnt     <= 4'hf;  // Start's own clock fall wraps it to zero
				is_addr <= 1'b1;
				rd      <= 1'b0;
				ack_me  <= 1'b0;
			end else if (stop_det) begin
				state     <= tw_pkg::PS_IDLE;
				addressed <= 1'b0;
			end
		end
	end
endmodule

// ===== rtl/tw_ctrl.sv
// Purpose: two-wire bus controller, APB registers, master and slave byte engine
// Assumes: open-drain wires via tw_bus_if, APB slave answers after one wait state
// Notes: one byte engine shared by master and slave; hold state stretches the clock
// What this block does
// - Enable bit gates the bus state machine; registers stay accessible
// - Interrupt enable bit gates the request
// - Master bit rising issues start, enters master
// - Master bit falling issues stop, back to slave
// - Transmit bit sets direction; transmit during address
// - Slave software sets transmit bit from slave direction
// - Receiver acknowledge follows the ack disable bit
// - Repeat start only as master; reads zero
// - Transfer done sets per byte; data access that starts a transfer clears
// - Address match or general call sets addressed flag
// - Busy follows detected start and stop
// - Arbitration lost flag set by hardware, write-one-clear
// - Slave direction flag holds calling read/write bit
// - Pending flag on byte, match, lost; write-one-clear
// - Received acknowledge reads zero when acknowledged
// - Master transmit data write sends byte MSB first
// - Master receive data read starts next byte
// - Software leaves receive mode before final read
// - Slave data accesses start transfers likewise
// - Transfer starts only if direction matches access
// - Data read returns last received byte only
// - First master byte is address plus direction
// - General call recognised only when enabled
`timescale 1ns/1ps
module tw_ctrl #(
	parameter int unsigned HALF_CYC = tw_pkg::SCL_HALF_CYC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [tw_pkg::AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       irq,
	tw_bus_if.dev                      tw
);
	tw_pkg::tw_state_t state;
	logic [tw_pkg::TW-1:0] tmr;
	logic [1:0] ph;
	logic [3:0] cnt;
	logic [7:0] sh, rx_data;
	logic [6:0] saddr;
	logic       en, ie, master_select, tx, ackdis, gcen;
	logic       transfer_done_flag, slave_addressed_flag, busy, arbitration_lost_flag, slave_direction_flag, iif, received_ack_flag;
	logic       bit_in, ack_me, is_addr, own, first, ack_q, queued;
	logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [7:0] c1_rd, st_rd, rd_mux;

	// Bus decode; the access takes effect at the edge where pready is high
	wire logic hit_c1  = paddr == tw_pkg::OFF_CTRL1;
	wire logic hit_st  = paddr == tw_pkg::OFF_STAT;
	wire logic hit_dat = paddr == tw_pkg::OFF_DATA;
	wire logic hit_c2  = paddr == tw_pkg::OFF_CTRL2;
	wire logic hit_sa  = paddr == tw_pkg::OFF_SADDR;
	wire logic hit     = hit_c1 | hit_st | hit_dat | hit_c2 | hit_sa;
	wire logic fire    = psel & penable & ack_q & hit;
	wire logic wr_c1   = fire & pwrite & hit_c1;
	wire logic wr_st   = fire & pwrite & hit_st;
	wire logic wr_c2   = fire & pwrite & hit_c2;
	wire logic wr_sa   = fire & pwrite & hit_sa;
	wire logic go_tx   = fire & pwrite & hit_dat & tx;
	wire logic go_rx   = fire & ~pwrite & hit_dat & ~tx;
	wire logic mst_up  = wr_c1 & pwdata[tw_pkg::B_MST] & ~master_select;
	wire logic mst_dn  = wr_c1 & ~pwdata[tw_pkg::B_MST] & master_select;
	wire logic repeat_start_cmd    = wr_c1 & pwdata[tw_pkg::B_REPEAT_START_CMD];
	wire logic repeat_start_cmd_ok = repeat_start_cmd & own & (state == tw_pkg::ST_HOLD);

	wire logic       start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire logic       stop_det  = scl_s & scl_d & ~sda_d & sda_s;
	wire logic       scl_rise  = scl_s & ~scl_d;
	wire logic       scl_fall  = ~scl_s & scl_d;
	wire logic       tmr_done  = tmr == '0;
	wire logic [7:0] byte_in   = {sh[6:0], bit_in};
	wire logic       gc_hit    = gcen & (byte_in[7:1] == tw_pkg::GC_ADDR);
	wire logic       match     = (byte_in[7:1] == saddr) | gc_hit;
	wire logic       ack_slot  = cnt == tw_pkg::ACK_SLOT;
	wire logic       m_pull    = ack_slot ? (~tx & ~ackdis) : (tx & ~sh[7]);
	wire logic       s_pull    = ack_slot ? ack_me : (~is_addr & tx & ~sh[7]);
	wire logic [tw_pkg::TW-1:0] half = tw_pkg::TW'(HALF_CYC);

	wire logic scl_pull = (state == tw_pkg::ST_MLOW) | (state == tw_pkg::ST_HOLD)
		| ((state == tw_pkg::ST_MSTART) & (ph == 2'h1))
		| ((state == tw_pkg::ST_MSTOP) & (ph == 2'h0))
		| ((state == tw_pkg::ST_MRSTA) & (ph == 2'h0));
	wire logic sda_pull = (state == tw_pkg::ST_MSTART)
		| ((state == tw_pkg::ST_MSTOP) & (ph != 2'h2))
		| ((state == tw_pkg::ST_MRSTA) & (ph == 2'h2))
		| (((state == tw_pkg::ST_MLOW) | (state == tw_pkg::ST_MHIGH)) & m_pull)
		| ((state == tw_pkg::ST_SBIT) & s_pull);

	assign tw.dev_scl_o   = 1'b0;
	assign tw.dev_sda_o   = 1'b0;
	assign tw.dev_scl_oen = ~scl_pull;
	assign tw.dev_sda_oen = ~sda_pull;
	assign irq            = iif & ie;
	assign pready         = ack_q;

	always_comb begin
		c1_rd                   = 8'h00;
		c1_rd[tw_pkg::B_EN]     = en;
		c1_rd[tw_pkg::B_IE]     = ie;
		c1_rd[tw_pkg::B_MST]    = master_select;
		c1_rd[tw_pkg::B_TX]     = tx;
		c1_rd[tw_pkg::B_ACKDIS] = ackdis;  // Repeat start field reads zero
		st_rd                   = 8'h00;
		st_rd[tw_pkg::B_TCF]    = transfer_done_flag;
		st_rd[tw_pkg::B_SLAVE_ADDRESSED_FLAG]   = slave_addressed_flag;
		st_rd[tw_pkg::B_BUSY]   = busy;
		st_rd[tw_pkg::B_ARBITRATION_LOST_FLAG]   = arbitration_lost_flag;
		st_rd[tw_pkg::B_SRW]    = slave_direction_flag;
		st_rd[tw_pkg::B_IIF]    = iif;
		st_rd[tw_pkg::B_RECEIVED_ACK_FLAG]   = received_ack_flag;
		rd_mux                  = 8'h00;
		if (hit_c1)
			rd_mux = c1_rd;
		else if (hit_st)
			rd_mux = st_rd;
		else if (hit_dat)
			rd_mux = rx_data;
		else if (hit_c2)
			rd_mux = {gcen, 7'h00};
		else if (hit_sa)
			rd_mux = {1'b0, saddr};
	end

	// One wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q   <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			ack_q   <= psel & penable & ~ack_q;
			prdata  <= {24'h00_0000, rd_mux};
			pslverr <= ~hit;
		end
	end

	// Two stages before any logic reads the wires
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {tw.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {tw.sda, sda_m, sda_s};
		end
	end

	// Software clears come first so hardware sets later in the block win
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en, ie, master_select, tx, ackdis, gcen} <= 6'h00;
			saddr   <= tw_pkg::RST_SADDR;
			transfer_done_flag     <= tw_pkg::RST_TCF;
			received_ack_flag    <= tw_pkg::RST_RECEIVED_ACK_FLAG;
			{slave_addressed_flag, busy, arbitration_lost_flag, slave_direction_flag, iif} <= 5'h00;
			rx_data <= 8'h00;
			state   <= tw_pkg::ST_IDLE;
			tmr     <= '0;
			ph      <= 2'h0;
			cnt     <= 4'h0;
			sh      <= 8'hff;
			{bit_in, ack_me, is_addr, own, first} <= 5'h10;
			queued  <= 1'b0;
		end else begin
			if (wr_c1) begin
				en     <= pwdata[tw_pkg::B_EN];
				ie     <= pwdata[tw_pkg::B_IE];
				master_select    <= pwdata[tw_pkg::B_MST];
				tx     <= pwdata[tw_pkg::B_TX];
				ackdis <= pwdata[tw_pkg::B_ACKDIS];
				slave_addressed_flag   <= 1'b0;
			end
			if (wr_c2)
				gcen <= pwdata[tw_pkg::B_GCEN];
			if (wr_sa)
				saddr <= pwdata[6:0];
			if (wr_st && pwdata[tw_pkg::B_ARBITRATION_LOST_FLAG])
				arbitration_lost_flag <= 1'b0;
			if (wr_st && pwdata[tw_pkg::B_IIF])
				iif <= 1'b0;
			if (go_tx || go_rx)
				transfer_done_flag <= 1'b0;
			if (start_det)
				busy <= 1'b1;
			if (stop_det)
				busy <= 1'b0;
			tmr <= tmr_done ? tmr : tmr - 1'b1;
			unique case (state)
				tw_pkg::ST_IDLE, tw_pkg::ST_SWAIT: begin
				end
				tw_pkg::ST_MSTART: begin
					// Software cannot see when the start ends, so an early address write is kept
					if (go_tx) begin
						sh     <= pwdata[7:0];
						queued <= 1'b1;
					end
					if (tmr_done) begin
						tmr <= half;
						if (ph == 2'h0)
							ph <= 2'h1;
						else begin
							state  <= (queued || go_tx) ? tw_pkg::ST_MLOW : tw_pkg::ST_HOLD;
							cnt    <= 4'h0;
							queued <= 1'b0;
							own    <= 1'b1;
							first  <= 1'b1;
						end
					end
				end
				tw_pkg::ST_MLOW: if (tmr_done) begin
					state <= tw_pkg::ST_MHIGH;
					tmr   <= half;
				end
				tw_pkg::ST_MHIGH: if (!scl_s) begin
					tmr <= half;                     // Slave stretching the clock
				end else if (tmr_done) begin
					if (!ack_slot && tx && sh[7] && !sda_s) begin
						// Lost: drop to slave receive, no stop issued
						arbitration_lost_flag    <= 1'b1;
						iif     <= 1'b1;
						master_select     <= 1'b0;
						own     <= 1'b0;
						state   <= tw_pkg::ST_SBIT;
						is_addr <= first;
						bit_in  <= sda_s;
						ack_me  <= 1'b0;
					end else if (!ack_slot) begin
						sh    <= {sh[6:0], sda_s};
						cnt   <= 4'(cnt + 4'h1);
						state <= tw_pkg::ST_MLOW;
						tmr   <= half;
					end else begin
						if (tx)
							received_ack_flag <= sda_s;
						else
							rx_data <= sh;
						transfer_done_flag   <= 1'b1;
						iif   <= 1'b1;
						first <= 1'b0;
						state <= tw_pkg::ST_HOLD;
					end
				end
				tw_pkg::ST_HOLD: if (own && !master_select) begin
					state <= tw_pkg::ST_MSTOP;
					ph    <= 2'h0;
					tmr   <= half;
				end else if (repeat_start_cmd_ok) begin
					state <= tw_pkg::ST_MRSTA;
					ph    <= 2'h0;
					tmr   <= half;
				end else if (go_tx || go_rx) begin
					cnt     <= 4'h0;
					is_addr <= 1'b0;
					tmr     <= half;
					if (go_tx)
						sh <= pwdata[7:0];
					state <= own ? tw_pkg::ST_MLOW : tw_pkg::ST_SBIT;
				end
				tw_pkg::ST_MSTOP, tw_pkg::ST_MRSTA: if (ph == 2'h1 && !scl_s) begin
					tmr <= half;
				end else if (tmr_done) begin
					tmr <= half;
					ph  <= 2'(ph + 2'h1);
					if (ph == 2'h2 && state == tw_pkg::ST_MSTOP) begin
						state <= tw_pkg::ST_IDLE;
						own   <= 1'b0;
					end else if (ph == 2'h2) begin
						state <= tw_pkg::ST_MSTART;
						ph    <= 2'h1;
					end
				end
				tw_pkg::ST_SBIT: begin
					if (scl_rise)
						bit_in <= sda_s;
					if (scl_fall && !ack_slot) begin
						sh  <= byte_in;
						cnt <= 4'(cnt + 4'h1);
						if (cnt == tw_pkg::LAST_BIT && is_addr) begin
							ack_me <= match;
							if (match) begin
								slave_addressed_flag <= 1'b1;
								slave_direction_flag  <= byte_in[0];
							end
						end else if (cnt == tw_pkg::LAST_BIT) begin
							ack_me <= ~tx & ~ackdis;
							if (!tx)
								rx_data <= byte_in;
						end
					end else if (scl_fall) begin
						ack_me <= 1'b0;
						if (tx && !is_addr)
							received_ack_flag <= bit_in;
						if (is_addr ? !ack_me : (tx && bit_in))
							state <= tw_pkg::ST_SWAIT;
						else begin
							transfer_done_flag   <= 1'b1;
							iif   <= 1'b1;
							state <= tw_pkg::ST_HOLD;
						end
					end
				end
			endcase
			if (mst_up) begin
				if (busy || state != tw_pkg::ST_IDLE) begin
					arbitration_lost_flag <= 1'b1;
					iif  <= 1'b1;
					master_select  <= 1'b0;
				end else begin
					state  <= tw_pkg::ST_MSTART;
					queued <= 1'b0;
					ph    <= 2'h0;
					tmr   <= half;
				end
			end
			if (repeat_start_cmd && !repeat_start_cmd_ok) begin
				arbitration_lost_flag <= 1'b1;
				iif  <= 1'b1;
			end
			if (start_det && !own && state != tw_pkg::ST_MSTART) begin
				state   <= tw_pkg::ST_SBIT;
				cnt     <= 4'hf;                     // Start's own clock fall wraps it to zero
				is_addr <= 1'b1;
				ack_me  <= 1'b0;
			end else if (stop_det && !own) begin
				state <= tw_pkg::ST_IDLE;
			end
			if (!en && !wr_c1) begin
				state <= tw_pkg::ST_IDLE;
				own   <= 1'b0;
			end
			if (mst_dn && state != tw_pkg::ST_HOLD && !own)
				master_select <= 1'b0;
		end
	end
endmodule

// ===== sim/tw_properties.sv
// Purpose: bus and register checks beside the two-wire link
// Assumes: one clock domain, async active-low reset
// Notes: busy compare waits for a quiet bus, sync lag is a few cycles
`timescale 1ns/1ps
module tw_props #(
	parameter int HALF = 6
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [tw_pkg::AW-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  irq,
	input wire logic                  dev_scl_oen,
	input wire logic                  dev_sda_oen,
	input wire logic                  scl,
	input wire logic                  sda
);
	localparam int HMAX = HALF + 4;
	logic       en;
	logic       busy;
	logic       scl_q;
	logic       sda_q;
	logic [2:0] quiet;
	wire        rd       = pready && !pwrite;
	wire        start_ev = scl && scl_q && sda_q && !sda;
	wire        stop_ev  = scl && scl_q && !sda_q && sda;
	wire        ctrl_wr  = pready && pwrite && paddr == tw_pkg::OFF_CTRL1;
	wire        mapped   = paddr inside {tw_pkg::OFF_CTRL1, tw_pkg::OFF_STAT, tw_pkg::OFF_DATA,
		tw_pkg::OFF_CTRL2, tw_pkg::OFF_SADDR};
	// Own view of the bus, kept apart from the design's synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_q, sda_q, busy, en} <= 4'h0 | 4'hc;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			busy  <= start_ev ? 1'b1 : (stop_ev ? 1'b0 : busy);
			en    <= ctrl_wr ? pwdata[tw_pkg::B_EN] : en;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet <= 3'h0;
		else
			quiet <= (start_ev || stop_ev) ? 3'h0 : (quiet == 3'h7 ? 3'h7 : quiet + 3'h1);
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_start;
		scl && $fell(sda);
	endsequence
	a_ready_wait: assert property (s_setup |=> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_irq_gate: assert property (rd && paddr == tw_pkg::OFF_CTRL1 && !prdata[tw_pkg::B_IE] |-> !irq)
		else $error("irq while interrupt enable clear");
	a_repeat_start_cmd_zero: assert property (rd && paddr == tw_pkg::OFF_CTRL1 |-> !prdata[tw_pkg::B_REPEAT_START_CMD])
		else $error("repeat start bit read as one");
	a_start_order: assert property (s_start |-> scl [*2] ##[1:HMAX] !scl)
		else $error("clock not lowered after start");
	a_stop_idle: assert property (scl && $rose(sda) |=> (scl && sda) [*3])
		else $error("bus not idle after stop");
	a_busy_track: assert property (rd && paddr == tw_pkg::OFF_STAT && quiet == 3'h7 |->
		prdata[tw_pkg::B_BUSY] == busy)
		else $error("busy flag differs from bus state");
	a_off_release: assert property (!en [*4] |-> dev_scl_oen && dev_sda_oen)
		else $error("lines driven while disabled");
endmodule

// ===== sim/test_two_wire_bus_register_control.sv
// Purpose: self-checking bench, controller and peer joined on one bus
// Assumes: 125 MHz pclk, short half bit for simulation
// Notes: no slave transfer completes here, the peer cannot act as master
`timescale 1ns/1ps
module test_two_wire_bus_register_control;
	localparam int         HALF = 6;
	localparam logic [7:0] CT   = tw_pkg::OFF_CTRL1;
	localparam logic [7:0] ST   = tw_pkg::OFF_STAT;
	localparam logic [7:0] DT   = tw_pkg::OFF_DATA;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        rx_strobe, addressed, hold_sda;
	logic [7:0]  paddr, tx_byte, rx_byte;
	logic [31:0] pwdata, prdata, rd;
	int          n_errors, comparisons;
	int          n_strobe;
	tw_bus_if tw_bus_if_i ();
	tw_ctrl #(.HALF_CYC(HALF)) tw_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .tw(tw_bus_if_i));
	tw_peer tw_peer_i (.pclk(pclk), .presetn(presetn), .tx_byte(tx_byte), .hold_scl(1'b0),
		.hold_sda(hold_sda), .rx_byte(rx_byte), .rx_strobe(rx_strobe), .addressed(addressed), .tw(tw_bus_if_i));
	tw_props #(.HALF(HALF)) tw_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .dev_scl_oen(tw_bus_if_i.dev_scl_oen),
		.dev_sda_oen(tw_bus_if_i.dev_sda_oen), .scl(tw_bus_if_i.scl), .sda(tw_bus_if_i.sda));
	// Peer strobes counted so a doubled or missing byte shows up
	always @(posedge pclk)
		if (rx_strobe === 1'b1)
			n_strobe <= n_strobe + 1;
	task automatic stop_test;
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One idle cycle after each access, so no strobe is driven twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t >= 50)
			n_errors++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		do begin
			apb(1'b0, ST, 32'h0);
			k++;
		end while ((rd & m) !== v && k < 300);
		check("status poll", rd & m, v);
	endtask
	task automatic t_reset;
		apb(1'b0, CT, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b0, ST, 32'h0);
		check("status reset", rd, 32'h81);
		apb(1'b0, DT, 32'h0);
		check("data reset", rd, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b1, tw_pkg::OFF_CTRL2, 32'h80);
		apb(1'b1, tw_pkg::OFF_SADDR, 32'h15);
		apb(1'b0, tw_pkg::OFF_CTRL2, 32'h0);
		check("general call enable", rd, 32'h80);
		apb(1'b0, tw_pkg::OFF_SADDR, 32'h0);
		check("slave address", rd, 32'h15);
	endtask
	task automatic t_refused;
		apb(1'b1, CT, 32'h84);
		apb(1'b0, ST, 32'h0);
		check("lost and pending", rd & 32'h12, 32'h12);
		apb(1'b0, CT, 32'h0);
		check("ctrl readback", rd, 32'h80);
		apb(1'b1, ST, 32'h10);
		apb(1'b0, ST, 32'h0);
		check("lost cleared", rd & 32'h12, 32'h02);
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, CT, 32'hc0);
		check("irq raised", {31'h0, irq}, 32'h1);
		apb(1'b1, ST, 32'h02);
		check("irq cleared", {31'h0, irq}, 32'h0);
	endtask
	task automatic t_mwrite;
		apb(1'b1, CT, 32'hb0);
		poll(32'h20, 32'h20);
		apb(1'b1, DT, {24'h0, tw_pkg::PEER_ADDR, 1'b0});
		poll(32'h02, 32'h02);
		check("after address", rd, 32'ha2);
		apb(1'b1, ST, 32'h02);
		check("peer addressed", {31'h0, addressed}, 32'h1);
		apb(1'b1, DT, 32'ha5);
		apb(1'b0, ST, 32'h0);
		check("done flag cleared", rd & 32'h80, 32'h0);
		poll(32'h02, 32'h02);
		check("peer byte", {24'h0, rx_byte}, 32'ha5);
		check("peer strobe count", n_strobe, 32'h1);
		apb(1'b1, ST, 32'h02);
		apb(1'b1, CT, 32'h90);
		poll(32'h20, 32'h0);
		check("peer released", {31'h0, addressed}, 32'h0);
	endtask
	// Peer holds data low, so the first one bit of the address loses
	task automatic t_lost;
		apb(1'b1, CT, 32'hb0);
		poll(32'h20, 32'h20);
		hold_sda <= 1'b1;
		apb(1'b1, DT, {24'h0, tw_pkg::PEER_ADDR, 1'b0});
		poll(32'h12, 32'h12);
		apb(1'b0, CT, 32'h0);
		check("lost drops master", rd & 32'h20, 32'h0);
		hold_sda <= 1'b0;
		poll(32'h20, 32'h0);
		apb(1'b1, ST, 32'h12);
		apb(1'b0, ST, 32'h0);
		check("lost flags cleared", rd & 32'h12, 32'h0);
	endtask
	task automatic t_mread;
		apb(1'b1, CT, 32'hb0);
		poll(32'h20, 32'h20);
		apb(1'b1, DT, {24'h0, tw_pkg::PEER_ADDR, 1'b1});
		poll(32'h03, 32'h02);
		apb(1'b1, ST, 32'h02);
		apb(1'b0, DT, 32'h0);
		check("no sent byte", rd, 32'h0);
		apb(1'b0, ST, 32'h0);
		check("no receive", rd & 32'h80, 32'h80);
		// Last byte is refused an acknowledge so the peer frees the data line
		apb(1'b1, CT, 32'ha8);
		apb(1'b0, DT, 32'h0);
		apb(1'b0, ST, 32'h0);
		check("receive started", rd & 32'h80, 32'h0);
		poll(32'h82, 32'h82);
		apb(1'b1, CT, 32'h80);
		apb(1'b0, DT, 32'h0);
		check("received byte", rd, {24'h0, tx_byte});
		poll(32'h20, 32'h0);
		apb(1'b1, CT, 32'h0);
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, hold_sda} = 5'h00;
		paddr = 8'h0;
		pwdata = 32'h0;
		tx_byte = 8'h3c;
		n_errors = 0;
		comparisons = 0;
		n_strobe = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_refused();
		t_mwrite();
		t_lost();
		t_mread();
		stop_test();
	end
endmodule
